// ---- verilog/dfrc_defs.svh ----
// Offsets, field positions, reset values and counts for the rate and filter controller
`ifndef DFRC_DEFS_SVH
`define DFRC_DEFS_SVH
// Register byte offsets
`define DFRC_ADDR_CTRL 12'h000
`define DFRC_ADDR_DECIM 12'h004
`define DFRC_ADDR_STATUS 12'h008
`define DFRC_ADDR_DATA 12'h00C
// Control fields
`define DFRC_CTRL_SPEED 0
`define DFRC_CTRL_FILT_LO 1
`define DFRC_CTRL_FILT_HI 2
`define DFRC_CTRL_CHAN_LO 4
`define DFRC_CTRL_CHAN_HI 6
// Status fields
`define DFRC_STAT_RDY 0
`define DFRC_STAT_ERR 1
`define DFRC_STAT_USED_LO 2
`define DFRC_STAT_USED_HI 3
`define DFRC_STAT_STAGE_LO 4
`define DFRC_STAT_STAGE_HI 5
// Modulator dividers, minus one, for speed bit 0 and 1
`define DFRC_DIV0_M1 8'h7F
`define DFRC_DIV1_M1 8'hFF
// Decimation ratio limits and reset value
`define DFRC_DECIM_MIN 11'h014
`define DFRC_DECIM_MAX 11'h7FF
`define DFRC_DECIM_RST 11'h100
// Saturation limits of the output word
`define DFRC_SAT_POS 32'h7FFFFFFF
`define DFRC_SAT_NEG 32'h80000000
`endif

// ---- verilog/dfrc_pkg.sv ----
// Types shared by the rate and filter controller
package dfrc_pkg;
	// Filter setting, also the filter in use for a word
	typedef enum logic [1:0] {
		DFRC_FAST = 2'b00,
		DFRC_SINC2 = 2'b01,
		DFRC_SINC3 = 2'b11,
		DFRC_AUTO = 2'b10
	} dfrc_filt_t;
	// Automatic mode stage since the last channel change
	typedef enum logic [1:0] {
		DFRC_ST_F0 = 2'b00,
		DFRC_ST_F1 = 2'b01,
		DFRC_ST_S2 = 2'b11,
		DFRC_ST_S3 = 2'b10
	} dfrc_stage_t;
endpackage : dfrc_pkg

// ---- verilog/dfrc_sinc.sv ----
// Cascaded integrator-comb sinc filter of selectable order
`timescale 1ns/1ps
`default_nettype none
module dfrc_sinc #(
	parameter int ORDER = 3, // Sinc order
	parameter int W = 36 // Accumulator width
) (
	input wire logic clk, // Oscillator clock
	input wire logic rst_b, // Async reset, active low
	input wire logic tick, // One modulator result
	input wire logic bit_in, // Modulator bit
	input wire logic dump, // End of decimation
	input wire logic clear, // Restart after channel change
	output logic [W-1:0] result // Signed filter output
);
	logic [W-1:0] integ_q [ORDER]; // Integrator chain
	logic [W-1:0] integ_d [ORDER]; // Integrator chain after this tick
	logic [W-1:0] dly_q [ORDER]; // Comb delays
	logic [W-1:0] comb [ORDER+1]; // Comb chain taps
	logic [W-1:0] x; // Bit as +1 or -1

	// Map 1 to +1 and 0 to -1
	assign x = {{(W-1){~bit_in}}, 1'b1};

	// Next integrator values, shared by the chain and the comb sample
	always_comb begin
		integ_d[0] = integ_q[0] + x;
		for (int k = 1; k < ORDER; k++) integ_d[k] = integ_q[k] + integ_q[k-1];
	end

	// Integrators; wraparound is harmless as W covers the gain
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int k = 0; k < ORDER; k++) integ_q[k] <= '0;
		end else if (clear) begin
			for (int k = 0; k < ORDER; k++) integ_q[k] <= '0;
		end else if (tick) begin
			for (int k = 0; k < ORDER; k++) integ_q[k] <= integ_d[k];
		end
	end

	// Comb chain; a dump on a tick samples after that tick so a word holds whole periods
	always_comb begin
		comb[0] = tick ? integ_d[ORDER-1] : integ_q[ORDER-1];
		for (int k = 0; k < ORDER; k++) comb[k+1] = comb[k] - dly_q[k];
	end

	// Combs advance once per output period
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int k = 0; k < ORDER; k++) dly_q[k] <= '0;
			result <= '0;
		end else if (clear) begin
			for (int k = 0; k < ORDER; k++) dly_q[k] <= '0;
			result <= '0;
		end else if (dump) begin
			for (int k = 0; k < ORDER; k++) dly_q[k] <= comb[k];
			result <= comb[ORDER];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_sinc_clear: assert property (clear |=> result == '0 && integ_q[0] == '0)
		else $error("sinc history not cleared");
	// result changes only at a dump or a clear
	chk_sinc_hold: assert property (!$past(dump) && !$past(clear) |-> $stable(result))
		else $error("sinc result moved between dumps");
endmodule : dfrc_sinc
`default_nettype wire

// ---- verilog/dfrc_top.sv ----
// Modulator clock divider, decimation and sinc filter sequencing with an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "dfrc_defs.svh"
module dfrc_top #(
	parameter int RES_W = 36 // Filter accumulator width
) (
	input wire logic CLK, // Oscillator clock
	input wire logic RST_B, // Async reset, active low
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB direction
	input wire logic [11:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error
	input wire logic MOD_BIT, // Modulator bitstream pin
	output logic MOD_CLK_OUT, // Modulator clock
	output logic [31:0] DATA_OUT, // Latest output word
	output logic DATA_READY, // New word pulse
	output var dfrc_pkg::dfrc_filt_t FILT_USED // Filter of latest word
);
	import dfrc_pkg::*;

	logic speed_q; // Divider select
	dfrc_filt_t mode_q; // Filter setting
	logic [2:0] chan_q; // Input channel
	logic [10:0] decim_q; // Decimation ratio
	logic rdy_q; // Sticky word-ready flag
	logic err_q; // Sticky rejected-ratio flag
	dfrc_stage_t stage_q; // Auto sequence stage
	logic [7:0] div_cnt_q; // Oscillator divider
	logic [10:0] dec_cnt_q; // Results in this period
	logic sync1_q, sync2_q; // Bitstream synchroniser
	logic dump_q; // Filters latched last cycle
	logic [31:0] prdata_q; // Read data
	logic [7:0] div_m1; // Divider terminal count
	logic mod_tick; // One modulator result
	logic dump; // End of decimation
	logic chan_chg; // Channel field changed
	logic wr, rd_setup, rd_data, wr_ctrl, wr_decim, wr_stat;
	logic decim_bad; // Requested ratio out of range
	logic [RES_W-1:0] res1, res2, res3; // Filter results
	logic [RES_W-1:0] sel_res; // Result of filter in use
	dfrc_filt_t used; // Filter in use for this word

	// Clamp a wide signed result to 32 bits, keeping its sign
	function automatic logic [31:0] dfrc_sat(input logic [RES_W-1:0] v);
		logic [RES_W-32:0] top;
		top = v[RES_W-1:31];
		if ((&top) || !(|top)) dfrc_sat = v[31:0];
		else if (v[RES_W-1]) dfrc_sat = `DFRC_SAT_NEG;
		else dfrc_sat = `DFRC_SAT_POS;
	endfunction : dfrc_sat

	// Bus decode; zero wait states so the master never stalls
	assign PREADY = 1'b1;
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign rd_data = PSEL && PENABLE && !PWRITE && PADDR == `DFRC_ADDR_DATA;
	assign wr_ctrl = wr && PADDR == `DFRC_ADDR_CTRL;
	assign wr_decim = wr && PADDR == `DFRC_ADDR_DECIM;
	assign wr_stat = wr && PADDR == `DFRC_ADDR_STATUS;
	assign decim_bad = PWDATA[31:11] != '0 || PWDATA[10:0] < `DFRC_DECIM_MIN;
	assign chan_chg = wr_ctrl && PWDATA[`DFRC_CTRL_CHAN_HI:`DFRC_CTRL_CHAN_LO] != chan_q;
	assign PRDATA = prdata_q;

	// Error for unmapped addresses and for a rejected ratio
	always_comb begin
		PSLVERR = 1'b0;
		if (PSEL && PENABLE) begin
			unique case (PADDR)
				`DFRC_ADDR_CTRL, `DFRC_ADDR_STATUS, `DFRC_ADDR_DATA: PSLVERR = 1'b0;
				`DFRC_ADDR_DECIM: PSLVERR = PWRITE && decim_bad;
				default: PSLVERR = 1'b1;
			endcase
		end
	end

	// Control register writes
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			speed_q <= 1'b0;
			mode_q <= DFRC_SINC3;
			chan_q <= 3'h0;
		end else if (wr_ctrl) begin
			speed_q <= PWDATA[`DFRC_CTRL_SPEED];
			mode_q <= dfrc_filt_t'(PWDATA[`DFRC_CTRL_FILT_HI:`DFRC_CTRL_FILT_LO]);
			chan_q <= PWDATA[`DFRC_CTRL_CHAN_HI:`DFRC_CTRL_CHAN_LO];
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) decim_q <= `DFRC_DECIM_RST;
		else if (wr_decim && !decim_bad) decim_q <= PWDATA[10:0];
	end

	// Sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			if (dump_q) rdy_q <= 1'b1;
			else if (rd_data) rdy_q <= 1'b0;
			if (wr_decim && decim_bad) err_q <= 1'b1;
			else if (wr_stat && PWDATA[`DFRC_STAT_ERR]) err_q <= 1'b0;
		end
	end

	// Read data captured in the setup phase
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) prdata_q <= 32'h00000000;
		else if (rd_setup) begin
			prdata_q <= 32'h00000000;
			unique case (PADDR)
				`DFRC_ADDR_CTRL: begin
					prdata_q[`DFRC_CTRL_SPEED] <= speed_q;
					prdata_q[`DFRC_CTRL_FILT_HI:`DFRC_CTRL_FILT_LO] <= mode_q;
					prdata_q[`DFRC_CTRL_CHAN_HI:`DFRC_CTRL_CHAN_LO] <= chan_q;
				end
				`DFRC_ADDR_DECIM: prdata_q[10:0] <= decim_q;
				`DFRC_ADDR_STATUS: begin
					prdata_q[`DFRC_STAT_RDY] <= rdy_q;
					prdata_q[`DFRC_STAT_ERR] <= err_q;
					prdata_q[`DFRC_STAT_USED_HI:`DFRC_STAT_USED_LO] <= FILT_USED;
					prdata_q[`DFRC_STAT_STAGE_HI:`DFRC_STAT_STAGE_LO] <= stage_q;
				end
				`DFRC_ADDR_DATA: prdata_q <= DATA_OUT;
				default: prdata_q <= 32'h00000000;
			endcase
		end
	end

	assign div_m1 = speed_q ? `DFRC_DIV1_M1 : `DFRC_DIV0_M1;
	assign mod_tick = div_cnt_q >= div_m1;

	// Divider restarts on a control write so the first period at a new speed is whole
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_cnt_q <= 8'h00;
			MOD_CLK_OUT <= 1'b0;
		end else begin
			div_cnt_q <= (mod_tick || wr_ctrl) ? 8'h00 : div_cnt_q + 8'h01;
			MOD_CLK_OUT <= speed_q ? div_cnt_q[7] : div_cnt_q[6];
		end
	end

	// Bitstream pin passes two flops before the filters
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= MOD_BIT;
			sync2_q <= sync1_q;
		end
	end

	assign dump = mod_tick && dec_cnt_q >= decim_q - 11'h001;

	// Result counter; an accepted ratio restarts the count so no period overshoots it
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) dec_cnt_q <= 11'h000;
		else if (chan_chg || dump || (wr_decim && !decim_bad)) dec_cnt_q <= 11'h000;
		else if (mod_tick) dec_cnt_q <= dec_cnt_q + 11'h001;
	end

	dfrc_sinc #(.ORDER(1), .W(RES_W)) u_fast (.clk(CLK), .rst_b(RST_B), .tick(mod_tick),
		.bit_in(sync2_q), .dump(dump), .clear(chan_chg), .result(res1));
	dfrc_sinc #(.ORDER(2), .W(RES_W)) u_sinc2 (.clk(CLK), .rst_b(RST_B), .tick(mod_tick),
		.bit_in(sync2_q), .dump(dump), .clear(chan_chg), .result(res2));
	dfrc_sinc #(.ORDER(3), .W(RES_W)) u_sinc3 (.clk(CLK), .rst_b(RST_B), .tick(mod_tick),
		.bit_in(sync2_q), .dump(dump), .clear(chan_chg), .result(res3));

	always_comb begin
		used = mode_q;
		if (mode_q == DFRC_AUTO) begin
			unique case (stage_q)
				DFRC_ST_F0, DFRC_ST_F1: used = DFRC_FAST;
				DFRC_ST_S2: used = DFRC_SINC2;
				DFRC_ST_S3: used = DFRC_SINC3;
			endcase
		end
		unique case (used)
			DFRC_FAST: sel_res = res1;
			DFRC_SINC2: sel_res = res2;
			default: sel_res = res3;
		endcase
	end

	// stage advances per word, restarts on channel change
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) stage_q <= DFRC_ST_F0;
		else if (chan_chg) stage_q <= DFRC_ST_F0;
		else if (dump_q) begin
			unique case (stage_q)
				DFRC_ST_F0: stage_q <= DFRC_ST_F1;
				DFRC_ST_F1: stage_q <= DFRC_ST_S2;
				DFRC_ST_S2, DFRC_ST_S3: stage_q <= DFRC_ST_S3;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			dump_q <= 1'b0;
			DATA_READY <= 1'b0;
			DATA_OUT <= 32'h00000000;
			FILT_USED <= DFRC_SINC3;
		end else begin
			dump_q <= dump && !chan_chg;
			DATA_READY <= dump_q;
			if (dump_q) begin
				DATA_OUT <= dfrc_sat(sel_res);
				FILT_USED <= used;
			end
		end
	end

	// Helper: cycles since the last modulator tick or control write
	logic [8:0] gap_q;
	logic seen_q;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			gap_q <= 9'h000;
			seen_q <= 1'b0;
		end else begin
			gap_q <= (mod_tick || wr_ctrl) ? 9'h000 : gap_q + 9'h001;
			seen_q <= (seen_q || mod_tick) && !wr_ctrl;
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	chk_div_period: assert property (mod_tick && seen_q |-> gap_q == (speed_q ? 9'h0FF : 9'h07F))
		else $error("modulator period wrong");
	chk_decim_reject: assert property (wr_decim && decim_bad |=> $stable(decim_q) && err_q)
		else $error("out-of-range ratio accepted");
	chk_decim_range: assert property (decim_q >= `DFRC_DECIM_MIN && decim_q <= `DFRC_DECIM_MAX)
		else $error("ratio outside range");
	chk_dump_count: assert property (dump && !$past(chan_chg) |-> dec_cnt_q == decim_q - 11'h001)
		else $error("dump at wrong count");
	// ready pulse is one cycle and marks a dump
	chk_ready_pulse: assert property (DATA_READY |-> $past(dump, 2) ##1 !DATA_READY[*8])
		else $error("ready pulse malformed");
	chk_word_sign: assert property (DATA_READY |-> DATA_OUT[31] == $past(sel_res[RES_W-1]))
		else $error("output sign mismatch");
	chk_auto_fast: assert property (dump_q && mode_q == DFRC_AUTO && (stage_q == DFRC_ST_F0
		|| stage_q == DFRC_ST_F1) && !chan_chg |=> FILT_USED == DFRC_FAST)
		else $error("auto mode skipped fast filter");
	chk_auto_sinc3: assert property (mode_q == DFRC_AUTO && stage_q == DFRC_ST_S2 && dump_q && !chan_chg
		|=> stage_q == DFRC_ST_S3 ##1 FILT_USED == DFRC_SINC2)
		else $error("auto sequence wrong");
	// sinc2 word comes from second order filter
	chk_sinc2_map: assert property (DATA_READY && FILT_USED == DFRC_SINC2 |-> DATA_OUT == dfrc_sat($past(res2)))
		else $error("sinc2 word mismatch");
	chk_ready_flag: assert property (DATA_READY |-> rdy_q)
		else $error("ready flag not set");
endmodule : dfrc_top
`default_nettype wire

// ---- test/dfrc_mod_model.sv ----
// Modulator bitstream source that answers on the block's modulator clock
`timescale 1ns/1ps
`default_nettype none
module dfrc_mod_model (
	input wire logic mod_clk, // Modulator clock from the block
	input wire logic rst_b, // Async reset, active low
	input wire logic level, // Wanted density, 1 is full scale positive
	output logic mod_bit // Bitstream to the block
);
	// New bit only on the modulator clock, as a real loop would
	always_ff @(posedge mod_clk or negedge rst_b) begin
		if (!rst_b) begin
			mod_bit <= 1'b0; // Idle output
		end else begin
			mod_bit <= level; // Constant density
		end
	end
endmodule : dfrc_mod_model
`default_nettype wire

// ---- test/test_dfrc_top.sv ----
// Self-checking bench for the rate and filter controller
`timescale 1ns/1ps
`default_nettype none
`include "dfrc_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module test_dfrc_top;
	import dfrc_pkg::*;
	// One case: speed, filter, ratio, input sign, settling periods
	typedef struct {logic spd; dfrc_filt_t filt; logic [10:0] dec; logic lvl; int ord;} dfrc_row_t;
	logic clk, rst_b, psel, penable, pwrite, lvl, mod_bit, mod_clk, rdy, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, dout, rd, expv;
	dfrc_filt_t fused;
	int num_errors, check_count, cyc, n;
	dfrc_row_t rows [3];
	logic [1:0] aexp [5];
	dfrc_top dfrc_top_i (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.MOD_BIT(mod_bit), .MOD_CLK_OUT(mod_clk), .DATA_OUT(dout), .DATA_READY(rdy), .FILT_USED(fused));
	dfrc_mod_model dfrc_mod_model_i (.mod_clk(mod_clk), .rst_b(rst_b), .level(lvl), .mod_bit(mod_bit));
	// Verdict and end of run
	task tally_and_finish;
		$display("checks=%0d mismatches=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// APB transfer, waits on pready, takes data at the same edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Edges until the next word, then the pulse must be gone
	task wait_word;
		n = 1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1);
		@(posedge clk);
		`CHK(rdy, 1'b0)
	endtask : wait_word
	// Edges between two rising modulator clock edges
	task mod_period;
		n = 0;
		while (mod_clk !== 1'b0) @(posedge clk);
		while (mod_clk !== 1'b1) @(posedge clk);
		while (mod_clk !== 1'b0) begin
			@(posedge clk);
			n++;
		end
		while (mod_clk !== 1'b1) begin
			@(posedge clk);
			n++;
		end
	endtask : mod_period
	// Free clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard, well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	// Main sequence
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lvl = 1'b1;
		rows[0] = '{1'b0, DFRC_FAST, 11'h014, 1'b1, 1};
		rows[1] = '{1'b0, DFRC_SINC2, 11'h015, 1'b0, 2};
		rows[2] = '{1'b1, DFRC_SINC3, 11'h019, 1'b1, 3};
		aexp = '{2'b00, 2'b00, 2'b01, 2'b11, 2'b11};
		repeat (2) @(posedge clk);
		`CHK({pready, pslverr, rdy, mod_clk, fused}, 6'h23)
		rst_b <= 1'b1;
		apb(1'b0, `DFRC_ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h00000006)
		apb(1'b0, `DFRC_ADDR_DECIM, 32'h0);
		`CHK(rd, 32'h00000100)
		apb(1'b0, `DFRC_ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0000000C)
		$display("reset test done");
		// Ordinary cases: rate, spacing, settling and sign per row
		for (int i = 0; i < 3; i++) begin
			lvl <= rows[i].lvl;
			apb(1'b1, `DFRC_ADDR_DECIM, {21'h0, rows[i].dec});
			apb(1'b1, `DFRC_ADDR_CTRL, {25'h0, 3'(i + 1), 1'b0, rows[i].filt, rows[i].spd});
			expv = 32'h1;
			for (int k = 0; k < rows[i].ord; k++) expv = expv * rows[i].dec;
			if (!rows[i].lvl) expv = -expv;
			for (int w = 1; w <= 4; w++) begin
				wait_word;
				if (w > 1) `CHK(n, rows[i].dec * (rows[i].spd ? 256 : 128))
				if (w == rows[i].ord) `CHK(dout, expv)
				if (w == rows[i].ord - 1) `CHK(dout !== expv, 1'b1)
			end
			`CHK(dout, expv)
			`CHK(fused, rows[i].filt)
			mod_period;
			`CHK(n, rows[i].spd ? 256 : 128)
			$display("row %0d done", i);
		end
		// Ratio limits: upper edge accepted, one past either edge refused
		apb(1'b1, `DFRC_ADDR_DECIM, 32'h00000013);
		`CHK(err, 1'b1)
		apb(1'b1, `DFRC_ADDR_DECIM, 32'h00000800);
		`CHK(err, 1'b1)
		apb(1'b0, `DFRC_ADDR_DECIM, 32'h0);
		`CHK(rd, 32'h00000019)
		apb(1'b1, `DFRC_ADDR_DECIM, 32'h000007FF);
		`CHK(err, 1'b0)
		apb(1'b0, 12'h010, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		apb(1'b0, `DFRC_ADDR_STATUS, 32'h0);
		`CHK(rd[`DFRC_STAT_ERR], 1'b1)
		$display("limit test done");
		// Automatic mode after a channel change
		lvl <= 1'b1;
		apb(1'b1, `DFRC_ADDR_DECIM, 32'h00000014);
		apb(1'b1, `DFRC_ADDR_CTRL, {25'h0, 3'h5, 1'b0, DFRC_AUTO, 1'b0});
		for (int w = 0; w < 5; w++) begin
			wait_word;
			`CHK(fused, aexp[w])
		end
		apb(1'b0, `DFRC_ADDR_DATA, 32'h0);
		`CHK(rd, 32'h00001F40)
		$display("auto test done");
		tally_and_finish;
	end
endmodule : test_dfrc_top
`default_nettype wire
